// >>> pkg/temp_result_regs.svh
// register addresses, reset values and coding constants of the result block
`ifndef TEMP_RESULT_REGS_SVH
`define TEMP_RESULT_REGS_SVH

// ==========================================================================
// register addresses
`define LOCAL_ADDR      8'h00
`define RINT_ADDR       8'h01
`define RFRAC_ADDR      8'h10
`define CFG_RD_ADDR     8'h03
`define CFG_WR_ADDR     8'h09
`define RATE_RD_ADDR    8'h04
`define RATE_WR_ADDR    8'h0A
`define REG_COUNT       22
`define REG_WIDTH       8

// ==========================================================================
// reset values
`define VALUE_RESET     8'h00
`define PTR_RESET       8'h00
`define CFG_RESET       8'h08
`define RATE_RESET      8'h06

// ==========================================================================
// fields and coding
`define RANGE_BIT       2
`define RATE_FAST_MIN   4'h8
`define AVG_LAST        4'hF
`define AVG_SHIFT       4
`define QTR_SHIFT       2
`define EXT_OFFSET      64
`define BIN_MIN_QTR     0
`define EXT_MIN_QTR     (-160)
`define MAX_QTR         500
`define EXT_MIN_CODE    8'h18
`define EXT_MAX_CODE    8'hBD
`define BIN_MAX_CODE    8'h7D
`define FRAC_LOW_MASK   8'h3F
`define BIT_LAST        3'h7
`define ZERO_BYTE       8'h00

`endif

// >>> pkg/temp_result_pkg.sv
// types shared by the temperature result block
package temp_result_pkg;

  // ==========================================================================
  // formatted result of one channel
  typedef struct packed {
    logic [7:0] whole;
    logic [1:0] quarter;
  } fmt_t;

  // ==========================================================================
  // value registers as seen by the limit logic
  typedef struct packed {
    logic [7:0] local_value;
    logic [7:0] remote_integer;
    logic [7:0] remote_fraction;
  } temp_result_t;

  // ==========================================================================
  // two-wire slave states
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ADDR,
    ST_ADDR_ACK,
    ST_WBYTE,
    ST_WACK,
    ST_RBYTE,
    ST_RACK
  } smb_state_t;

endpackage : temp_result_pkg

// >>> core/temp_result_registers.sv
// temperature result registers with two-wire register access
`timescale 1ns/10ps
`default_nettype none
`include "temp_result_regs.svh"

module temp_result_registers
  import temp_result_pkg::*;
#(
  parameter int       MEAS_W     = 11,
  parameter bit [6:0] SLAVE_ADDR = 7'h2A  // arbitrary default
) (
  input  wire logic              MCLK,
  input  wire logic              NRST,
  input  wire logic              CE,
  input  wire logic              SCL_I,
  input  wire logic              SDA_I,
  output logic                   SDA_O,
  output logic                   SDA_OE,
  input  wire logic              MEAS_VALID,
  input  wire logic              MEAS_REMOTE,
  input  wire logic [MEAS_W-1:0] MEAS_TEMP,
  output logic                   RANGE_EXT,
  output logic [3:0]             CONV_RATE,
  output temp_result_t           RESULTS,
  output logic                   REMOTE_LOCKED
);

  localparam int SW = MEAS_W + `AVG_SHIFT;

  // ==========================================================================
  // result coding: clamp, offset, split into whole and quarter
  function automatic fmt_t fmt(input logic signed [MEAS_W-1:0] q, input logic ext);
    int   qi;
    int   lo;
    int   wi;
    fmt_t r;
    qi = int'(q);
    lo = ext ? `EXT_MIN_QTR : `BIN_MIN_QTR;
    if (qi < lo) qi = lo;
    if (qi > `MAX_QTR) qi = `MAX_QTR;
    wi = (qi >>> `QTR_SHIFT) + (ext ? `EXT_OFFSET : 0);
    r.whole   = 8'(wi);
    r.quarter = 2'(qi);
    return r;
  endfunction : fmt

  // ==========================================================================
  // pin synchronisers and filtered levels
  logic [2:0] scl_s_q, sda_s_q;
  logic       scl_f_q, sda_f_q;
  wire        scl_n = (scl_s_q[1] == scl_s_q[2]) ? scl_s_q[2] : scl_f_q;
  wire        sda_n = (sda_s_q[1] == sda_s_q[2]) ? sda_s_q[2] : sda_f_q;
  wire        scl_rise = scl_n & ~scl_f_q;
  wire        scl_fall = ~scl_n & scl_f_q;
  wire        bus_start = scl_f_q & scl_n & sda_f_q & ~sda_n;
  wire        bus_stop  = scl_f_q & scl_n & ~sda_f_q & sda_n;

  always_ff @(posedge MCLK or negedge NRST) begin
    if (!NRST) begin
      scl_s_q <= 3'h7;
      sda_s_q <= 3'h7;
      scl_f_q <= 1'b1;
      sda_f_q <= 1'b1;
    end else if (CE) begin
      scl_s_q <= {scl_s_q[1:0], SCL_I};
      sda_s_q <= {sda_s_q[1:0], SDA_I};
      scl_f_q <= scl_n;
      sda_f_q <= sda_n;
    end
  end

  // ==========================================================================
  // register state
  smb_state_t state_q, state_d;
  logic [2:0] bit_q, bit_d;
  logic [7:0] sh_q, sh_d;
  logic       oe_q, oe_d;
  logic       first_q, first_d;
  logic       rw_q, rw_d;
  logic       ack_q, ack_d;
  logic [7:0] ptr_q, ptr_d;
  logic [7:0] cfg_q, rate_q;
  logic [7:0] local_q, rint_q, rfrac_q;
  logic       lock_q;
  logic       ptr_wr, reg_wr, load_rd;

  // ==========================================================================
  // read selection, following the pointer
  wire [7:0] rd_data = (ptr_q == `LOCAL_ADDR)   ? local_q :
                       (ptr_q == `RINT_ADDR)    ? rint_q  :
                       (ptr_q == `RFRAC_ADDR)   ? rfrac_q :
                       (ptr_q == `CFG_RD_ADDR)  ? cfg_q   :
                       (ptr_q == `RATE_RD_ADDR) ? rate_q  : `ZERO_BYTE;
  wire       cfg_wr  = reg_wr & (ptr_q == `CFG_WR_ADDR);
  wire       rate_wr = reg_wr & (ptr_q == `RATE_WR_ADDR);
  wire       frac_rd = load_rd & (ptr_q == `RFRAC_ADDR);
  wire       int_rd  = load_rd & (ptr_q == `RINT_ADDR);
  wire       range_chg = cfg_wr & (sh_d[`RANGE_BIT] != cfg_q[`RANGE_BIT]);
  // taken from the held bits so the slave process reads no value it drives itself
  wire       sh_addr_ok = (sh_q[6:0] == SLAVE_ADDR);

  // ==========================================================================
  // two-wire slave: no clock stretching, pointer not auto-incremented
  always_comb begin
    state_d = state_q;
    bit_d   = bit_q;
    sh_d    = sh_q;
    oe_d    = oe_q;
    first_d = first_q;
    rw_d    = rw_q;
    ack_d   = ack_q;
    ptr_d   = ptr_q;
    ptr_wr  = 1'b0;
    reg_wr  = 1'b0;
    load_rd = 1'b0;
    if (bus_start) begin
      state_d = ST_ADDR;
      bit_d   = 3'h0;
      oe_d    = 1'b0;
      first_d = 1'b1;
    end else if (bus_stop) begin
      state_d = ST_IDLE;
      oe_d    = 1'b0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          oe_d = 1'b0;
        end
        ST_ADDR, ST_WBYTE: begin
          if (scl_rise) begin
            sh_d  = {sh_q[6:0], sda_n};
            bit_d = bit_q + 3'h1;
            if (bit_q == `BIT_LAST) begin
              if (state_q == ST_ADDR) begin
                rw_d    = sh_d[0];
                state_d = sh_addr_ok ? ST_ADDR_ACK : ST_IDLE;
              end else begin
                state_d = ST_WACK;
                if (first_q) begin
                  ptr_d  = sh_d;
                  ptr_wr = 1'b1;
                end else begin
                  reg_wr = 1'b1;
                end
                first_d = 1'b0;
              end
            end
          end
        end
        ST_ADDR_ACK, ST_WACK: begin
          if (scl_fall) begin
            if (oe_q) begin
              oe_d = 1'b0;
              if (state_q == ST_ADDR_ACK && rw_q) begin
                state_d = ST_RBYTE;
                sh_d    = rd_data;
                load_rd = 1'b1;
                oe_d    = ~rd_data[7];
                bit_d   = 3'h0;
              end else begin
                state_d = ST_WBYTE;
              end
            end else begin
              oe_d = 1'b1;
            end
          end
        end
        ST_RBYTE: begin
          if (scl_fall) begin
            if (bit_q == `BIT_LAST) begin
              state_d = ST_RACK;
              oe_d    = 1'b0;
            end else begin
              sh_d  = {sh_q[6:0], 1'b0};
              oe_d  = ~sh_q[6];
              bit_d = bit_q + 3'h1;
            end
          end
        end
        ST_RACK: begin
          if (scl_rise) ack_d = ~sda_n;
          if (scl_fall) begin
            if (ack_q) begin
              state_d = ST_RBYTE;
              sh_d    = rd_data;
              load_rd = 1'b1;
              oe_d    = ~rd_data[7];
              bit_d   = 3'h0;
            end else begin
              state_d = ST_IDLE;
            end
          end
        end
        default: begin
          state_d = ST_IDLE;
          oe_d    = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge MCLK or negedge NRST) begin
    if (!NRST) begin
      state_q <= ST_IDLE;
      bit_q   <= 3'h0;
      sh_q    <= `ZERO_BYTE;
      oe_q    <= 1'b0;
      first_q <= 1'b0;
      rw_q    <= 1'b0;
      ack_q   <= 1'b0;
      ptr_q   <= `PTR_RESET;
    end else if (CE) begin
      state_q <= state_d;
      bit_q   <= bit_d;
      sh_q    <= sh_d;
      oe_q    <= oe_d;
      first_q <= first_d;
      rw_q    <= rw_d;
      ack_q   <= ack_d;
      ptr_q   <= ptr_d;
    end
  end

  // ==========================================================================
  // configuration and rate; limits live elsewhere and are never touched here
  always_ff @(posedge MCLK or negedge NRST) begin
    if (!NRST) begin
      cfg_q  <= `CFG_RESET;
      rate_q <= `RATE_RESET;
    end else if (CE) begin
      if (cfg_wr) cfg_q <= sh_d;
      if (rate_wr) rate_q <= sh_d;
    end
  end

  // ==========================================================================
  // averaging per channel
  logic signed [SW-1:0] acc_q [2];
  logic [3:0]           cnt_q [2];
  wire                  ch = MEAS_REMOTE;
  wire                  fast = (rate_q[3:0] >= `RATE_FAST_MIN);
  wire                  ext = cfg_q[`RANGE_BIT];
  wire                  meas_ok = MEAS_VALID & ~range_chg;
  wire signed [SW-1:0]  meas_x = SW'(signed'(MEAS_TEMP));
  wire signed [SW-1:0]  acc_sum = acc_q[ch] + meas_x;
  wire                  avg_done = meas_ok & (fast | (cnt_q[ch] == `AVG_LAST));
  wire [MEAS_W-1:0]     avg_val = fast ? MEAS_TEMP
                                       : MEAS_W'(acc_sum >>> `AVG_SHIFT);
  wire fmt_t            res = fmt(avg_val, ext);
  wire                  store_local  = avg_done & ~ch;
  wire                  store_remote = avg_done & ch & ~lock_q;

  always_ff @(posedge MCLK or negedge NRST) begin
    if (!NRST) begin
      acc_q <= '{default: '0};
      cnt_q <= '{default: '0};
    end else if (CE) begin
      if (range_chg) begin
        acc_q <= '{default: '0};
        cnt_q <= '{default: '0};
      end else if (meas_ok) begin
        acc_q[ch] <= avg_done ? '0 : acc_sum;
        cnt_q[ch] <= avg_done ? 4'h0 : cnt_q[ch] + 4'h1;
      end
    end
  end

  // ==========================================================================
  // value registers: written only by the conversion path
  always_ff @(posedge MCLK or negedge NRST) begin
    if (!NRST) begin
      local_q <= `VALUE_RESET;
      rint_q  <= `VALUE_RESET;
      rfrac_q <= `VALUE_RESET;
      lock_q  <= 1'b0;
    end else if (CE) begin
      if (store_local) local_q <= res.whole;
      if (store_remote) begin
        rint_q  <= res.whole;
        rfrac_q <= {res.quarter, 6'h00};
      end
      if (frac_rd) lock_q <= 1'b1;
      else if (int_rd) lock_q <= 1'b0;
    end
  end

  // ==========================================================================
  // outputs
  assign SDA_O         = 1'b0;
  assign SDA_OE        = oe_q;
  assign RANGE_EXT     = cfg_q[`RANGE_BIT];
  assign CONV_RATE     = rate_q[3:0];
  assign RESULTS       = '{local_value: local_q, remote_integer: rint_q,
                           remote_fraction: rfrac_q};
  assign REMOTE_LOCKED = lock_q;

  // ==========================================================================
  // checks
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!NRST);

  sequence s_frac_read;
    CE && frac_rd;
  endsequence
  sequence s_no_int_read;
    !int_rd;
  endsequence

  AST_LOCK_HOLD: assert property (s_frac_read ##1 s_no_int_read |=> $stable(rint_q))
    else $error("remote integer changed while locked");
  AST_HOST_NO_WRITE: assert property (CE && reg_wr && ptr_q == `LOCAL_ADDR && !store_local
                                      |=> $stable(local_q))
    else $error("host write altered local value");
  AST_FRAC_LOW: assert property ((rfrac_q & `FRAC_LOW_MASK) == `ZERO_BYTE)
    else $error("fraction low bits not zero");
  AST_BIN_MAX: assert property (CE && store_local && !ext |=> local_q <= `BIN_MAX_CODE)
    else $error("binary result above 125");
  AST_BIN_NEG: assert property (CE && store_local && !ext && avg_val[MEAS_W-1]
                                |=> local_q == `ZERO_BYTE)
    else $error("negative not clamped to zero");
  AST_EXT_SPAN: assert property (CE && store_local && ext
                                 |=> local_q >= `EXT_MIN_CODE
                                     && local_q <= `EXT_MAX_CODE)
    else $error("extended result out of span");
  AST_PTR_LOAD: assert property (CE && ptr_wr |=> ptr_q == $past(sh_d))
    else $error("pointer not loaded by first byte");
  AST_PTR_KEEP: assert property (!ptr_wr |=> $stable(ptr_q))
    else $error("pointer changed without a write");
  AST_FAST_DIRECT: assert property (meas_ok && fast |-> avg_done)
    else $error("fast rate result not stored at once");
  AST_SLOW_AVG: assert property (avg_done && !fast |-> cnt_q[ch] == `AVG_LAST)
    else $error("average stored before sixteen samples");
  AST_RANGE_FLUSH: assert property (CE && range_chg
                                    |=> cnt_q[0] == 4'h0 && cnt_q[1] == 4'h0)
    else $error("range change did not restart averaging");

endmodule : temp_result_registers
`default_nettype wire

// >>> tb/smb_host_model.sv
// two-wire host model that issues pointer writes, register writes and reads
`timescale 1ns/10ps
`default_nettype none

module smb_host_model #(
  parameter bit [6:0] DEV_ADDR = 7'h2A,  // arbitrary, must match the device
  parameter int       QTR      = 4
) (
  input  wire logic MCLK,
  input  wire logic SDA_LINE,
  output var logic  SCL,
  output var logic  SDA_REL
);
  // ==========================================================================
  // bus phases
  // each phase lasts QTR cycles or more so the device filter keeps pace
  initial begin
    SCL = 1'b1;
    SDA_REL = 1'b1;
  end

  task automatic wait_n(input int n);
    repeat (n) @(negedge MCLK);
  endtask : wait_n

  task automatic start_cond();
    SDA_REL = 1'b1;
    wait_n(QTR);
    SCL = 1'b1;
    wait_n(QTR);
    SDA_REL = 1'b0;
    wait_n(QTR);
    SCL = 1'b0;
    wait_n(QTR);
  endtask : start_cond

  task automatic stop_cond();
    SDA_REL = 1'b0;
    wait_n(QTR);
    SCL = 1'b1;
    wait_n(QTR);
    SDA_REL = 1'b1;
    wait_n(2 * QTR);
  endtask : stop_cond

  // sample late in the high phase, well after the device's filtered rise
  task automatic bit_xfer(input logic b, output logic r);
    SDA_REL = b;
    wait_n(QTR);
    SCL = 1'b1;
    wait_n(2 * QTR);
    r = SDA_LINE;
    SCL = 1'b0;
    wait_n(QTR);
  endtask : bit_xfer

  // ==========================================================================
  // byte and register transfers
  task automatic byte_out(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_xfer(d[i], r);
    bit_xfer(1'b1, r);
    ack = ~r;
  endtask : byte_out

  task automatic byte_in(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bit_xfer(1'b1, d[i]);
    bit_xfer(last, r);
  endtask : byte_in

  task automatic write_reg(input logic [7:0] ptr, input logic [7:0] data,
                           input logic with_data, output logic ok);
    logic a0;
    logic a1;
    logic a2;
    a2 = 1'b1;
    start_cond();
    byte_out({DEV_ADDR, 1'b0}, a0);
    byte_out(ptr, a1);
    if (with_data) byte_out(data, a2);
    stop_cond();
    ok = a0 & a1 & a2;
  endtask : write_reg

  task automatic read_reg(output logic [7:0] d, output logic ok);
    start_cond();
    byte_out({DEV_ADDR, 1'b1}, ok);
    byte_in(1'b1, d);
    stop_cond();
  endtask : read_reg
endmodule : smb_host_model

`default_nettype wire

// >>> tb/tb_temp_result_registers.sv
// self-checking bench for the temperature result registers
`timescale 1ns/10ps
`default_nettype none

module tb_temp_result_registers
  import temp_result_pkg::*;
;
  localparam bit [6:0] ADDR  = 7'h2A;  // arbitrary, shared by device and host
  localparam int       LIMIT = 40000;
  logic         mclk    = 1'b0;
  logic         nrst    = 1'b0;
  logic         ce      = 1'b1;
  logic         mvalid  = 1'b0;
  logic         mremote = 1'b0;
  logic [10:0]  mtemp   = 11'h000;
  wire logic    scl;
  wire logic    sda_rel;
  wire logic    sda_o;
  wire logic    sda_oe;
  wire logic    range_ext;
  wire logic    locked;
  wire logic [3:0] rate;
  temp_result_t res;
  int           n_fail  = 0;
  int           checks  = 0;
  int           cycles  = 0;
  // open drain with pull-up: low whenever either side pulls
  wire logic    sda_line = sda_rel & ~(sda_oe & ~sda_o);

  always #25 mclk = ~mclk;

  temp_result_registers #(.SLAVE_ADDR(ADDR)) temp_result_registers_i (
    .MCLK(mclk), .NRST(nrst), .CE(ce), .SCL_I(scl), .SDA_I(sda_line),
    .SDA_O(sda_o), .SDA_OE(sda_oe), .MEAS_VALID(mvalid), .MEAS_REMOTE(mremote),
    .MEAS_TEMP(mtemp), .RANGE_EXT(range_ext), .CONV_RATE(rate), .RESULTS(res),
    .REMOTE_LOCKED(locked));

  smb_host_model #(.DEV_ADDR(ADDR)) smb_host_model_i (
    .MCLK(mclk), .SDA_LINE(sda_line), .SCL(scl), .SDA_REL(sda_rel));

  // ==========================================================================
  // tasks
  task automatic close_out();
    if (n_fail == 0 && checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : close_out

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic meas(input logic rem, input logic [10:0] q);
    mvalid = 1'b1;
    mremote = rem;
    mtemp = q;
    @(negedge mclk);
    mvalid = 1'b0;
    repeat (2) @(negedge mclk);
  endtask : meas

  task automatic mc(input logic rem, input logic [10:0] q,
                    input logic [7:0] ei, input logic [7:0] ef);
    meas(rem, q);
    if (rem) begin
      chk(res.remote_integer, ei);
      chk(res.remote_fraction, ef);
    end else begin
      chk(res.local_value, ei);
    end
  endtask : mc

  task automatic wr(input logic [7:0] ptr, input logic [7:0] data);
    logic a;
    smb_host_model_i.write_reg(ptr, data, 1'b1, a);
    chk({7'h00, a}, 8'h01);
  endtask : wr

  task automatic rd_here(input logic [7:0] exp);
    logic [7:0] d;
    logic       a;
    smb_host_model_i.read_reg(d, a);
    chk({7'h00, a}, 8'h01);
    chk(d, exp);
  endtask : rd_here

  task automatic rd(input logic [7:0] ptr, input logic [7:0] exp);
    logic a;
    smb_host_model_i.write_reg(ptr, 8'h00, 1'b0, a);
    chk({7'h00, a}, 8'h01);
    rd_here(exp);
  endtask : rd

  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      n_fail++;
      close_out();
    end
  end

  // ==========================================================================
  // sequence
  initial begin
    repeat (12) @(negedge mclk);
    nrst = 1'b1;
    @(negedge mclk);
    chk(res.local_value, 8'h00);
    chk(res.remote_integer, 8'h00);
    chk(res.remote_fraction, 8'h00);
    chk({7'h00, range_ext}, 8'h00);
    chk({4'h0, rate}, 8'h06);
    // default rate is slow: fifteen samples leave the register alone
    for (int i = 0; i < 15; i++) meas(1'b0, 11'h028 + 11'(i));
    chk(res.local_value, 8'h00);
    mc(1'b0, 11'h037, 8'h0B, 8'h00);
    rd_here(8'h0B);
    rd_here(8'h0B);
    rd(8'h03, 8'h08);
    for (int r = 8; r <= 10; r++) begin
      wr(8'h0A, 8'(r));
      rd(8'h04, 8'(r));
      mc(1'b0, 11'(r * 4), 8'(r), 8'h00);
    end
    mc(1'b0, 11'h1F8, 8'h7D, 8'h00);
    mc(1'b0, 11'h7F8, 8'h00, 8'h00);
    mc(1'b0, 11'h064, 8'h19, 8'h00);
    mc(1'b1, 11'h064, 8'h19, 8'h00);
    mc(1'b1, 11'h066, 8'h19, 8'h80);
    mc(1'b1, 11'h067, 8'h19, 8'hC0);
    mc(1'b1, 11'h1F7, 8'h7D, 8'h00);
    mc(1'b1, 11'h065, 8'h19, 8'h40);
    rd(8'h10, 8'h40);
    chk({7'h00, locked}, 8'h01);
    mc(1'b1, 11'h0C8, 8'h19, 8'h40);
    rd(8'h01, 8'h19);
    chk({7'h00, locked}, 8'h00);
    mc(1'b1, 11'h0C8, 8'h32, 8'h00);
    wr(8'h00, 8'h55);
    rd(8'h00, 8'h19);
    wr(8'h01, 8'h55);
    rd(8'h01, 8'h32);
    rd(8'h05, 8'h00);
    wr(8'h09, 8'h0C);
    chk({7'h00, range_ext}, 8'h01);
    rd(8'h03, 8'h0C);
    mc(1'b0, 11'h000, 8'h40, 8'h00);
    mc(1'b0, 11'h738, 8'h18, 8'h00);
    mc(1'b1, 11'h761, 8'h18, 8'h40);
    mc(1'b1, 11'h258, 8'hBD, 8'h00);
    wr(8'h09, 8'h08);
    mc(1'b0, 11'h064, 8'h19, 8'h00);
    // clock enable low: a measurement must leave the value untouched
    ce = 1'b0;
    meas(1'b0, 11'h0C8);
    chk(res.local_value, 8'h19);
    ce = 1'b1;
    mc(1'b0, 11'h0C8, 8'h32, 8'h00);
    close_out();
  end
endmodule : tb_temp_result_registers

`default_nettype wire
